//--- core/dpscd_dev.sv
// device end: two-wire command decoder for two 64-tap wipers
`default_nettype none
module dpscd_dev #(
  parameter int NV_CYC = dpscd_pkg::NV_PROG_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // link
  dpscd_if.dev link,
  // address straps
  input wire logic strap_addr_bit3,
  input wire logic strap_addr_bit2,
  input wire logic strap_addr_bit1,
  input wire logic strap_addr_bit0,
  // wiper positions and status
  output logic [dpscd_pkg::WIPER_W-1:0] wiper0_pos,
  output logic [dpscd_pkg::WIPER_W-1:0] wiper1_pos,
  output logic nv_busy
);
  import dpscd_pkg::*;

  localparam logic [NV_CNT_W-1:0] NV_LOAD = NV_CNT_W'(NV_CYC);

  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_d_r;
  logic sda_d_r;
  logic [3:0] strap_s1_r;
  logic [3:0] strap_s2_r;
  dpscd_dev_st_e st_r;
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  logic [7:0] shift_r;
  logic [7:0] instr_r;
  logic [7:0] tx_r;
  logic sda_oe_r;
  logic [WIPER_W-1:0] wiper_r [NUM_POTS];
  logic [WIPER_W-1:0] nv_r [NUM_SETTINGS];
  logic [WIPER_W-1:0] pval_r [NUM_POTS];
  logic [1:0] pend_r;
  logic [1:0] pidx_r;
  logic [NV_CNT_W-1:0] nv_cnt_r;

  // only the second stage of each synchroniser is read
  wire scl_s = scl_sync_r[1];
  wire sda_s = sda_sync_r[1];
  wire start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire rise_ev = scl_s & ~scl_d_r;
  wire fall_ev = ~scl_s & scl_d_r;
  wire bit_full = (bit_r == ACK_BIT);

  // decode of the byte just received and of the held instruction byte instr_r
  wire [3:0] op_now = shift_r[7:4];
  wire p_now = shift_r[2];
  wire [1:0] idx_now = shift_r[1:0];
  wire p_cmd = instr_r[2];
  wire [3:0] op_cmd = instr_r[7:4];
  wire addr_hit = (shift_r[7:4] == TYPE_CODE)
                & (shift_r[3:0] == strap_s2_r)
                & (nv_cnt_r == '0);
  wire op_legal = ~shift_r[3] & (op_now == OP_RD_WPR
                | op_now == OP_WR_WPR | op_now == OP_RD_SSR
                | op_now == OP_WR_SSR | op_now == OP_SSR2W
                | op_now == OP_W2SSR | op_now == OP_G_SSR2W
                | op_now == OP_G_W2SSR | op_now == OP_STEP);
  wire byte_ok = (byte_r == 2'h0) ? addr_hit
               : (byte_r == 2'h1) ? op_legal : 1'b1;
  wire take_byte = (st_r == D_RECV) & fall_ev & bit_full & byte_ok;
  wire take_instr = take_byte & (byte_r == 2'h1);
  wire take_data = take_byte & (byte_r == 2'h2);
  wire is_rd = (op_cmd == OP_RD_WPR) | (op_cmd == OP_RD_SSR);
  wire is_wr3 = (op_cmd == OP_WR_WPR) | (op_cmd == OP_WR_SSR);
  wire is_step = (op_cmd == OP_STEP);
  wire [WIPER_W-1:0] rd_val = (op_now == OP_RD_WPR) ? wiper_r[p_now]
                            : nv_r[{p_now, idx_now}];
  // step as a clock pulse ends; a stop's rising clock is no pulse
  wire [WIPER_W-1:0] cur_w = wiper_r[p_cmd];
  wire [WIPER_W-1:0] step_val =
    sda_d_r ? ((cur_w == WIPER_MAX) ? cur_w : cur_w + 6'h01)
            : ((cur_w == WIPER_MIN) ? cur_w : cur_w - 6'h01);
  wire step_ev = (st_r == D_STEP) & fall_ev;

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = sda_oe_r;
  assign wiper0_pos = wiper_r[0];
  assign wiper1_pos = wiper_r[1];
  assign nv_busy = (nv_cnt_r != '0);

  // input synchronisers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      strap_s1_r <= 4'h0;
      strap_s2_r <= 4'h0;
    end else begin
      scl_sync_r <= {scl_sync_r[0], link.scl};
      sda_sync_r <= {sda_sync_r[0], link.sda};
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      strap_s1_r <= {strap_addr_bit3, strap_addr_bit2,
                     strap_addr_bit1, strap_addr_bit0};
      strap_s2_r <= strap_s1_r;
    end
  end

  // link sequencer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= D_IDLE;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      shift_r <= 8'h00;
      instr_r <= 8'h00;
      tx_r <= 8'h00;
      sda_oe_r <= 1'b0;
    end else if (start_ev) begin
      st_r <= D_RECV;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_ev) begin
      st_r <= D_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (st_r)
        D_RECV: begin
          if (rise_ev && !bit_full) begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_r <= bit_r + 4'h1;
          end else if (fall_ev && bit_full) begin
            if (byte_ok) begin
              st_r <= D_ACK;
              sda_oe_r <= 1'b1;
            end else begin
              st_r <= D_SKIP;
            end
            if (take_instr) begin
              instr_r <= shift_r;
              tx_r <= {2'b00, rd_val};
            end
          end
        end
        D_ACK: begin
          if (fall_ev) begin
            sda_oe_r <= 1'b0;
            bit_r <= 4'h0;
            byte_r <= byte_r + 2'h1;
            if (byte_r == 2'h0) begin
              st_r <= D_RECV;
            end else if (byte_r == 2'h1 && is_rd) begin
              st_r <= D_SEND;
              sda_oe_r <= ~tx_r[7];
            end else if (byte_r == 2'h1 && is_wr3) begin
              st_r <= D_RECV;
            end else if (byte_r == 2'h1 && is_step) begin
              st_r <= D_STEP;
            end else begin
              st_r <= D_SKIP;
            end
          end
        end
        D_SEND: begin
          if (fall_ev) begin
            if (bit_r == LAST_TX_BIT) begin
              sda_oe_r <= 1'b0;
              st_r <= D_SKIP;
            end else begin
              bit_r <= bit_r + 4'h1;
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_r <= ~tx_r[6];
            end
          end
        end
        D_IDLE, D_STEP, D_SKIP: begin
          sda_oe_r <= 1'b0;
        end
        default: begin
          st_r <= D_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // wiper and stored-setting storage
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int p = 0; p < NUM_POTS; p++) begin
        wiper_r[p] <= WIPER_RST;
        pval_r[p] <= WIPER_RST;
      end
      for (int i = 0; i < NUM_SETTINGS; i++) begin
        nv_r[i] <= SETTING_RST;
      end
      pend_r <= 2'h0;
      pidx_r <= 2'h0;
      nv_cnt_r <= '0;
    end else begin
      if (nv_cnt_r != '0) begin
        nv_cnt_r <= nv_cnt_r - 1'b1;
      end
      if (take_instr) begin
        case (op_now)
          OP_SSR2W: begin
            wiper_r[p_now] <= nv_r[{p_now, idx_now}];
          end
          OP_G_SSR2W: begin
            for (int p = 0; p < NUM_POTS; p++) begin
              wiper_r[p] <= nv_r[{p[0], idx_now}];
            end
          end
          OP_W2SSR: begin
            pend_r[p_now] <= 1'b1;
            pval_r[p_now] <= wiper_r[p_now];
            pidx_r <= idx_now;
          end
          OP_G_W2SSR: begin
            for (int p = 0; p < NUM_POTS; p++) begin
              pend_r[p] <= 1'b1;
              pval_r[p] <= wiper_r[p];
            end
            pidx_r <= idx_now;
          end
          default: begin
          end
        endcase
      end
      if (take_data) begin
        if (op_cmd == OP_WR_WPR) begin
          wiper_r[p_cmd] <= shift_r[WIPER_W-1:0];
        end else begin
          pend_r[p_cmd] <= 1'b1;
          pval_r[p_cmd] <= shift_r[WIPER_W-1:0];
          pidx_r <= instr_r[1:0];
        end
      end
      if (step_ev) begin
        wiper_r[p_cmd] <= step_val;
      end
      if (start_ev) begin
        pend_r <= 2'h0;
      end else if (stop_ev && pend_r != 2'h0) begin
        for (int p = 0; p < NUM_POTS; p++) begin
          if (pend_r[p]) begin
            nv_r[{p[0], pidx_r}] <= pval_r[p];
          end
        end
        pend_r <= 2'h0;
        nv_cnt_r <= NV_LOAD;
      end
    end
  end
endmodule
`default_nettype wire

//--- core/dpscd_host.sv
// host end: bus master that frames commands on the two-wire link
`default_nettype none
module dpscd_host (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // link
  dpscd_if.host link,
  // command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [3:0] cmd_strap,
  input wire logic [7:0] cmd_instr,
  input wire logic [7:0] cmd_data,
  input wire logic [7:0] cmd_steps,
  // response port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  import dpscd_pkg::*;

  localparam logic [2:0] QTR_LAST = 3'(QTR_CYC - 1);

  dpscd_host_st_e st_r;
  logic [2:0] div_r;
  logic [1:0] q_r;
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  logic [7:0] steps_r;
  logic [3:0] strap_r;
  logic [7:0] instr_r;
  logic [7:0] data_r;
  logic [7:0] rx_r;
  logic nack_r;
  logic scl_r;
  logic sda_oe_r;
  logic [1:0] sda_sync_r;
  logic rsp_valid_r;
  logic [7:0] rsp_data_r;
  logic rsp_nack_r;

  wire sda_s = sda_sync_r[1];
  wire tick = (div_r == QTR_LAST);
  wire slot_end = tick & (q_r == 2'h3);
  wire [3:0] op = instr_r[7:4];
  wire is_rd = (op == OP_RD_WPR) | (op == OP_RD_SSR);
  wire is_wr3 = (op == OP_WR_WPR) | (op == OP_WR_SSR);
  wire is_step = (op == OP_STEP);
  wire rx_phase = (byte_r == 2'h2) & is_rd;
  wire last_byte = (byte_r == 2'h2) | ((byte_r == 2'h1) & ~(is_rd | is_wr3));
  wire [7:0] tx_byte = (byte_r == 2'h0) ? {TYPE_CODE, strap_r}
                     : (byte_r == 2'h1) ? instr_r : data_r;
  wire [2:0] tx_pos = 3'h7 - bit_r[2:0];
  // pin levels per slot; bit data changes while the clock is low, start and stop change it while the clock is high
  wire xfer_drv = (bit_r == ACK_BIT) ? 1'b0
                : (rx_phase ? 1'b0 : ~tx_byte[tx_pos]);
  wire drv_w = (st_r == H_START) ? q_r[1]
             : (st_r == H_XFER) ? xfer_drv
             : (st_r == H_STEP) ? ~data_r[0]
             : (st_r == H_STOP) ? (q_r != 2'h3) : 1'b0;
  wire hold_drv = (q_r == 2'h0) & ((st_r == H_XFER) | (st_r == H_STEP)
                | (st_r == H_STOP));
  wire scl_w = ((st_r == H_XFER) | (st_r == H_STEP) | (st_r == H_STOP))
             ? q_r[1] : 1'b1;

  assign cmd_ready = (st_r == H_IDLE);
  assign link.host_scl = scl_r;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = sda_oe_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_data = rsp_data_r;
  assign rsp_nack = rsp_nack_r;

  // clock divider and pins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_r <= 3'h0;
      q_r <= 2'h0;
      scl_r <= 1'b1;
      sda_oe_r <= 1'b0;
      sda_sync_r <= 2'h3;
    end else begin
      sda_sync_r <= {sda_sync_r[0], link.sda};
      scl_r <= scl_w;
      if (!hold_drv) begin
        sda_oe_r <= drv_w;
      end
      if (st_r == H_IDLE || tick) begin
        div_r <= 3'h0;
      end else begin
        div_r <= div_r + 3'h1;
      end
      if (st_r == H_IDLE) begin
        q_r <= 2'h0;
      end else if (tick) begin
        q_r <= q_r + 2'h1;
      end
    end
  end

  // frame sequencer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= H_IDLE;
      bit_r <= 4'h0;
      byte_r <= 2'h0;
      steps_r <= 8'h00;
      strap_r <= 4'h0;
      instr_r <= 8'h00;
      data_r <= 8'h00;
      rx_r <= 8'h00;
      nack_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 8'h00;
      rsp_nack_r <= 1'b0;
    end else begin
      rsp_valid_r <= 1'b0;
      case (st_r)
        H_IDLE: begin
          if (cmd_valid) begin
            st_r <= H_START;
            strap_r <= cmd_strap;
            instr_r <= cmd_instr;
            data_r <= cmd_data;
            steps_r <= cmd_steps;
            nack_r <= 1'b0;
            rx_r <= 8'h00;
            bit_r <= 4'h0;
            byte_r <= 2'h0;
          end
        end
        H_START: begin
          if (slot_end) begin
            st_r <= H_XFER;
          end
        end
        H_XFER: begin
          if (slot_end && bit_r != ACK_BIT) begin
            bit_r <= bit_r + 4'h1;
            if (rx_phase) begin
              rx_r <= {rx_r[6:0], sda_s};
            end
          end else if (slot_end) begin
            bit_r <= 4'h0;
            if (!rx_phase && sda_s) begin
              nack_r <= 1'b1;
              st_r <= H_STOP;
            end else if (!last_byte) begin
              byte_r <= byte_r + 2'h1;
            end else if (is_step && steps_r != 8'h00) begin
              st_r <= H_STEP;
            end else begin
              st_r <= H_STOP;
            end
          end
        end
        H_STEP: begin
          if (slot_end) begin
            steps_r <= steps_r - 8'h01;
            if (steps_r == 8'h01) begin
              st_r <= H_STOP;
            end
          end
        end
        H_STOP: begin
          if (slot_end) begin
            st_r <= H_IDLE;
            rsp_valid_r <= 1'b1;
            rsp_data_r <= rx_r;
            rsp_nack_r <= nack_r;
          end
        end
        default: begin
          st_r <= H_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- core/dpscd_if.sv
// two-wire link between host and device, open-drain data line
`default_nettype none
interface dpscd_if;
  logic host_scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  assign scl = host_scl;
  // pulled up; any enabled driver may pull it low
  assign sda = (host_sda_oe ? host_sda_o : 1'b1)
             & (dev_sda_oe ? dev_sda_o : 1'b1);
  modport host (output host_scl, output host_sda_o, output host_sda_oe,
                input sda);
  modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

//--- core/dpscd_pkg.sv
// shared constants and types of the dual pot serial command decoder
`default_nettype none
package dpscd_pkg;
  localparam int CORE_CLK_MHZ = 50;
  localparam int NV_PROG_US = 5000;
  localparam int NV_PROG_CYC = NV_PROG_US * CORE_CLK_MHZ;
  localparam int NV_CNT_W = 18;
  // device type code on the link; value is arbitrary
  localparam logic [3:0] TYPE_CODE = 4'h9;
  localparam int WIPER_W = 6;
  localparam int NUM_POTS = 2;
  localparam int NUM_SETTINGS = 8;
  localparam logic [5:0] WIPER_MAX = 6'h3f;
  localparam logic [5:0] WIPER_MIN = 6'h00;
  localparam logic [5:0] WIPER_RST = 6'h00;
  localparam logic [5:0] SETTING_RST = 6'h00;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  localparam int QTR_CYC = 4;
  // instruction opcodes, upper nibble of the instruction byte
  localparam logic [3:0] OP_RD_WPR = 4'h9;
  localparam logic [3:0] OP_WR_WPR = 4'ha;
  localparam logic [3:0] OP_RD_SSR = 4'hb;
  localparam logic [3:0] OP_WR_SSR = 4'hc;
  localparam logic [3:0] OP_SSR2W = 4'hd;
  localparam logic [3:0] OP_W2SSR = 4'he;
  localparam logic [3:0] OP_G_SSR2W = 4'h1;
  localparam logic [3:0] OP_G_W2SSR = 4'h8;
  localparam logic [3:0] OP_STEP = 4'h2;
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_RECV = 3'h1,
    D_ACK = 3'h2,
    D_SEND = 3'h3,
    D_STEP = 3'h4,
    D_SKIP = 3'h5
  } dpscd_dev_st_e;
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_START = 3'h1,
    H_XFER = 3'h2,
    H_STEP = 3'h3,
    H_STOP = 3'h4
  } dpscd_host_st_e;
endpackage
`default_nettype wire

//--- sim/dpscd_chk.sv
// link checker for the dual pot serial command decoder
`default_nettype none
module dpscd_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // link
  input wire logic host_scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  a_host_pull_only: assert property (host_sda_oe |-> !host_sda_o)
    else $error("host drives data line high");
  a_dev_pull_only: assert property (
    dev_sda_oe |-> !dev_sda_o && !sda)
    else $error("device enable does not pull data low");
  a_reset_idle: assert property ($fell(srst) |->
    host_scl && !host_sda_oe && !dev_sda_oe)
    else $error("link not idle after reset");
  a_scl_high_len: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase too short");
  a_scl_low_len: assert property ($fell(scl) |-> !scl[*8] ##1 scl)
    else $error("clock low phase not eight cycles");
  a_ack_in_low: assert property ($rose(dev_sda_oe) |-> !scl[*4])
    else $error("device drive starts outside clock low");
  a_release_low: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("device releases data while clock high");
  a_dev_hold_high: assert property ($rose(scl) && dev_sda_oe |->
    dev_sda_oe[*8])
    else $error("device data not held over clock high");
endmodule
`default_nettype wire

//--- sim/dual_pot_serial_command_decoder_tb.sv
// testbench: host and device joined on the two-wire link
`default_nettype none
module dual_pot_serial_command_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dpscd_pkg::*;
  localparam int NV = 200;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  logic [3:0] cmd_strap = 4'h5;
  logic [7:0] cmd_instr = 8'h00;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] cmd_steps = 8'h00;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_nack;
  logic [3:0] strap_r = 4'h5;
  logic [3:0] cur_st = 4'h5;
  logic [5:0] wiper0_pos;
  logic [5:0] wiper1_pos;
  logic nv_busy;
  logic [7:0] rd_r;
  logic nack_r;
  int busy_n;
  int miscompares = 0;
  int total_checks = 0;

  always #10 core_clk = ~core_clk;

  dpscd_if dpscd_if_inst();
  dpscd_dev #(.NV_CYC(NV)) dpscd_dev_inst (
    .core_clk(core_clk), .srst(srst), .link(dpscd_if_inst),
    .strap_addr_bit3(strap_r[3]), .strap_addr_bit2(strap_r[2]),
    .strap_addr_bit1(strap_r[1]), .strap_addr_bit0(strap_r[0]),
    .wiper0_pos(wiper0_pos), .wiper1_pos(wiper1_pos), .nv_busy(nv_busy));
  dpscd_host dpscd_host_inst (
    .core_clk(core_clk), .srst(srst), .link(dpscd_if_inst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_strap(cmd_strap),
    .cmd_instr(cmd_instr), .cmd_data(cmd_data), .cmd_steps(cmd_steps),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  dpscd_chk dpscd_chk_inst (
    .core_clk(core_clk), .srst(srst),
    .host_scl(dpscd_if_inst.host_scl),
    .host_sda_o(dpscd_if_inst.host_sda_o),
    .host_sda_oe(dpscd_if_inst.host_sda_oe),
    .dev_sda_o(dpscd_if_inst.dev_sda_o),
    .dev_sda_oe(dpscd_if_inst.dev_sda_oe),
    .scl(dpscd_if_inst.scl), .sda(dpscd_if_inst.sda));

  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // one full frame; busy_n counts device busy cycles inside the frame
  task automatic do_cmd(input logic [7:0] ins, input logic [7:0] dat,
                        input logic [7:0] stp);
    int n;
    n = 0;
    busy_n = 0;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_strap <= cur_st;
    cmd_instr <= ins;
    cmd_data <= dat;
    cmd_steps <= stp;
    do @(posedge core_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
      if (nv_busy === 1'b1) busy_n++;
    end
    if (n >= 2000) begin
      miscompares++;
      $display("[ERR] response exp pulse got none");
    end
    rd_r = rsp_data;
    nack_r = rsp_nack;
  endtask

  task automatic wait_busy;
    busy_n = 0;
    while (nv_busy !== 1'b0 && busy_n < 400) begin
      @(posedge core_clk);
      busy_n++;
    end
    if (busy_n >= 400) begin
      miscompares++;
      $display("[ERR] busy end exp 0 got 1");
    end
  endtask

  task automatic t_wiper;
    do_cmd(8'ha0, 8'hea, 8'h00);
    chk("wr ack", 8'h00, {7'h0, nack_r});
    chk("wiper0", 8'h2a, {2'b00, wiper0_pos});
    do_cmd(8'ha4, 8'hff, 8'h00);
    chk("wiper1", 8'h3f, {2'b00, wiper1_pos});
    do_cmd(8'h90, 8'h00, 8'h00);
    chk("rd wiper0", 8'h2a, rd_r);
    do_cmd(8'h94, 8'h00, 8'h00);
    chk("rd wiper1", 8'h3f, rd_r);
    $display("test wiper done");
  endtask

  task automatic t_setting;
    do_cmd(8'hc3, 8'h15, 8'h00);
    chk("busy in frame", 8'h01, {7'h0, busy_n < 8});
    chk("busy after", 8'h01, {7'h0, nv_busy});
    do_cmd(8'h90, 8'h00, 8'h00);
    chk("busy refuse", 8'h01, {7'h0, nack_r});
    wait_busy;
    do_cmd(8'hb3, 8'h00, 8'h00);
    chk("rd setting", 8'h15, rd_r);
    $display("test setting done");
  endtask

  task automatic t_copy;
    do_cmd(8'he1, 8'h00, 8'h00);
    wait_busy;
    chk("busy span", 8'h01, {7'h0, busy_n inside {[NV-16:NV]}});
    do_cmd(8'ha0, 8'h00, 8'h00);
    do_cmd(8'hd1, 8'h00, 8'h00);
    chk("copy to wiper", 8'h2a, {2'b00, wiper0_pos});
    do_cmd(8'hb1, 8'h00, 8'h00);
    chk("copy to setting", 8'h2a, rd_r);
    do_cmd(8'h82, 8'h00, 8'h00);
    wait_busy;
    do_cmd(8'ha0, 8'h00, 8'h00);
    do_cmd(8'ha4, 8'h00, 8'h00);
    do_cmd(8'h12, 8'h00, 8'h00);
    chk("global w0", 8'h2a, {2'b00, wiper0_pos});
    chk("global w1", 8'h3f, {2'b00, wiper1_pos});
    $display("test copy done");
  endtask

  task automatic t_step;
    do_cmd(8'ha0, 8'h02, 8'h00);
    do_cmd(8'h20, 8'h00, 8'h05);
    chk("step floor", 8'h00, {2'b00, wiper0_pos});
    do_cmd(8'h20, 8'h01, 8'h04);
    chk("step up", 8'h04, {2'b00, wiper0_pos});
    chk("other pot", 8'h3f, {2'b00, wiper1_pos});
    do_cmd(8'h24, 8'h01, 8'h03);
    chk("step ceiling", 8'h3f, {2'b00, wiper1_pos});
    $display("test step done");
  endtask

  task automatic t_refuse;
    cur_st = 4'h6;
    do_cmd(8'ha0, 8'h11, 8'h00);
    chk("foreign nack", 8'h01, {7'h0, nack_r});
    chk("foreign w0", 8'h04, {2'b00, wiper0_pos});
    strap_r <= 4'ha;
    cur_st = 4'ha;
    repeat (4) @(posedge core_clk);
    do_cmd(8'ha0, 8'h11, 8'h00);
    chk("new strap w0", 8'h11, {2'b00, wiper0_pos});
    do_cmd(8'ha8, 8'h22, 8'h00);
    chk("bad instr nack", 8'h01, {7'h0, nack_r});
    chk("bad instr w0", 8'h11, {2'b00, wiper0_pos});
    $display("test refuse done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_wiper;
    t_setting;
    t_copy;
    t_step;
    t_refuse;
    complete_run;
  end

  initial begin
    #(20 * 40000);
    miscompares++;
    $display("[ERR] watchdog exp done got hang");
    complete_run;
  end
endmodule
`default_nettype wire
